// File: pmbrt_pkg.sv
package pmbrt_pkg;
    // widths of the pci and local data paths
    localparam int PMBRT_DATA_W = 64;
    localparam int PMBRT_HALF_W = 32;
    localparam int PMBRT_TSR_W = 10;
    // transfer-status bit positions
    localparam int PMBRT_TSR_ADDR_BIT = 2;
    localparam int PMBRT_TSR_DATA_BIT = 3;
    localparam int PMBRT_TSR_XFER_BIT = 8;
    localparam int PMBRT_TSR_WIDE_BIT = 9;
    // reset values
    localparam logic [PMBRT_TSR_W-1:0] PMBRT_TSR_RESET = 10'h000;
    localparam logic [PMBRT_DATA_W-1:0] PMBRT_DATA_RESET = 64'h0;
    // depth of the pci-to-local holding stage, in words
    localparam int PMBRT_HOLD_DEPTH = 2;
    // master sequencer states, one-hot
    typedef enum logic [3:0] {
        PMBRT_IDLE = 4'h1,
        PMBRT_ADDR = 4'h2,
        PMBRT_DATA = 4'h4,
        PMBRT_DONE = 4'h8
    } pmbrt_state_t;
endpackage

// File: pmbrt_hold.sv
`timescale 1ns/1ps
// small holding stage: words captured from pci wait here for the local master
module pmbrt_hold #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    output logic [WIDTH-1:0] head_o,
    output logic avail_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);
    // depth must hold the two in-flight data phases
    initial begin
        if (DEPTH < 2) begin
            $error("pmbrt_hold: depth below two");
        end
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    logic do_pop;
    // a pop only ever takes a word that is really present
    assign do_pop = pop_i && (cnt_reg != '0);
    // storage, one flip-flop row per entry
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    mem_reg[g] <= '0;
                end else if (push_i && (wr_reg == PW'(g))) begin
                    mem_reg[g] <= push_data_i;
                end
            end
        end
    endgenerate
    // pointers wrap at depth
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push_i) begin
                wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
        end
    end
    // occupancy count
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= '0;
        end else if (push_i && !do_pop) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else if (do_pop && !push_i) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    assign head_o = mem_reg[rd_reg];
    assign avail_o = (cnt_reg != '0);
    assign count_o = cnt_reg;
endmodule

// File: pmbrt_core.sv
`timescale 1ns/1ps
// Overview of operation
// - final request: drop frame, req64, keep irdy while ready
// - acknowledge while captured pci data waits
// - strobe when acknowledge and ready last cycle
// - strobe qualifies data with both dword acks
// - status bit 8 after successful pci phase
// - after last phase, irdy/devsel/ack64/trdy released
// - data mode end clears bit 3, ack, strobe
// - narrow request: no req64, upper lanes invalid
// - ready dropped: next cycle strobe off, irdy off in middle phases
// - target wait with no captured word held: next cycle ack, strobe off
// - first phase irdy always, last phase forced, middle need ready
// - at most two phases after final request
// - bit 3 in data mode, bit 9 wide
module pmbrt_core
    import pmbrt_pkg::*;
#(
    parameter int DATA_W = pmbrt_pkg::PMBRT_DATA_W,
    parameter int HOLD_DEPTH = pmbrt_pkg::PMBRT_HOLD_DEPTH
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // local master side, active low
    input wire logic local_narrow_request_n_i,
    input wire logic local_wide_request_n_i,
    input wire logic local_final_transfer_request_n_i,
    input wire logic local_master_ready_n_i,
    output logic master_data_acknowledge_n_o,
    output logic local_data_transfer_strobe_n_o,
    output logic low_dword_ack_n_o,
    output logic high_dword_ack_n_o,
    output logic [DATA_W-1:0] local_data_o,
    output logic [pmbrt_pkg::PMBRT_TSR_W-1:0] master_transfer_status_o,
    // pci side
    input wire logic gnt_n_i,
    input wire logic [DATA_W-1:0] ad_i,
    input wire logic trdy_n_i,
    input wire logic devsel_n_i,
    input wire logic ack64_n_i,
    output logic frame_n_o,
    output logic frame_oe_o,
    output logic req64_n_o,
    output logic req64_oe_o,
    output logic irdy_n_o,
    output logic irdy_oe_o,
    output logic req_n_o
);
    import pmbrt_pkg::*;
    localparam int CW = $clog2(HOLD_DEPTH+1);
    // the local data path is the full pci width
    initial begin
        if (DATA_W != PMBRT_DATA_W) begin
            $error("pmbrt_core: data width must be 64");
        end
        // the next-word path below knows only two entries, the head and the newer one
        if (HOLD_DEPTH != 2) begin
            $error("pmbrt_core: hold depth must be two");
        end
    end

    pmbrt_state_t state_reg; // sequencer state
    logic frame_reg; // frame asserted (active high internal)
    logic irdy_reg; // irdy asserted
    logic wide_reg; // req64 asserted this transaction
    logic first_reg; // no data phase done yet
    logic last_seen_reg; // final transfer request latched
    logic drv_reg; // drivers on for frame/irdy
    logic ack_reg; // acknowledge asserted
    logic dxfr_reg; // transfer strobe asserted
    logic [PMBRT_TSR_W-1:0] tsr_reg; // transfer status
    logic [DATA_W-1:0] dout_reg; // local output data
    logic req_reg; // bus request
    logic phase_ok; // data phase completes this edge
    logic rdy_q; // local ready sampled last cycle
    logic hold_avail;
    logic [DATA_W-1:0] hold_head;
    logic [CW-1:0] hold_count;
    logic pop;
    logic trdy_ok;
    logic want_local;
    logic last_req; // final transfer flagged now or in an earlier cycle
    logic [DATA_W-1:0] tail_reg; // newest word pushed into the hold

    // a data phase completes when both ready lines are low
    assign trdy_ok = !trdy_n_i;
    assign phase_ok = irdy_reg && trdy_ok;
    assign want_local = !local_narrow_request_n_i || !local_wide_request_n_i;
    // a word leaves the hold in the very cycle its strobe is out, so it is never sent twice
    assign pop = hold_avail && ack_reg && rdy_q;
    // a live final request counts at once, so no third phase slips in
    assign last_req = last_seen_reg || !local_final_transfer_request_n_i;

    // captured pci words wait here until the local master takes them
    pmbrt_hold #(
        .WIDTH(DATA_W),
        .DEPTH(HOLD_DEPTH)
    ) u_hold (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .push_i(phase_ok),
        .push_data_i(ad_i),
        .pop_i(pop),
        .head_o(hold_head),
        .avail_o(hold_avail),
        .count_o(hold_count)
    );

    // ready from the previous cycle, as the strobe needs it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= !local_master_ready_n_i;
        end
    end

    // transaction sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= PMBRT_IDLE;
        end else begin
            case (state_reg)
                PMBRT_IDLE: begin
                    if (want_local && !gnt_n_i) begin
                        state_reg <= PMBRT_ADDR;
                    end
                end
                PMBRT_ADDR: begin
                    state_reg <= PMBRT_DATA;
                end
                PMBRT_DATA: begin
                    // finished once frame is gone and the last phase completed
                    if (!frame_reg && phase_ok) begin
                        state_reg <= PMBRT_DONE;
                    end
                end
                PMBRT_DONE: begin
                    // data mode lasts until every held word is delivered
                    if (!hold_avail || (pop && hold_count == CW'(1))) begin
                        state_reg <= PMBRT_IDLE;
                    end
                end
                default: begin
                    state_reg <= PMBRT_IDLE;
                end
            endcase
        end
    end

    // bus request follows the local request while idle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_reg <= 1'b0;
        end else begin
            req_reg <= want_local && (state_reg == PMBRT_IDLE);
        end
    end

    // frame, req64 and the final-request latch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_reg <= 1'b0;
            wide_reg <= 1'b0;
            last_seen_reg <= 1'b0;
        end else if (state_reg == PMBRT_IDLE && want_local && !gnt_n_i) begin
            frame_reg <= 1'b1;
            // narrow request never raises req64; upper lanes are don't care
            wide_reg <= !local_wide_request_n_i;
            last_seen_reg <= !local_final_transfer_request_n_i;
        end else begin
            // the end cycle clears the latch, but a request in that same cycle wins
            if (state_reg == PMBRT_DONE) begin
                last_seen_reg <= 1'b0;
            end
            if (!local_final_transfer_request_n_i) begin
                last_seen_reg <= 1'b1;
            end
            // final request plus a completed phase: frame and req64 drop
            if (frame_reg && last_req && phase_ok) begin
                frame_reg <= 1'b0;
                wide_reg <= 1'b0;
            end
        end
    end

    // irdy: forced on first and last phase, gated by ready in between; off after last phase
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irdy_reg <= 1'b0;
            first_reg <= 1'b1;
            drv_reg <= 1'b0;
        end else if (state_reg == PMBRT_ADDR) begin
            irdy_reg <= 1'b1;
            first_reg <= 1'b1;
            drv_reg <= 1'b1;
        end else if (state_reg == PMBRT_DATA) begin
            if (!frame_reg && phase_ok) begin
                irdy_reg <= 1'b0;
            end else if (!frame_reg) begin
                irdy_reg <= 1'b1; // last phase keeps irdy
            end else if (first_reg && !phase_ok) begin
                irdy_reg <= 1'b1;
            end else begin
                // a local stall pulls irdy in the next cycle
                irdy_reg <= !local_master_ready_n_i;
            end
            if (phase_ok) begin
                first_reg <= 1'b0;
            end
        end else begin
            irdy_reg <= 1'b0;
            // drivers come on with frame at the grant; the end cycle drives them high
            drv_reg <= (state_reg == PMBRT_DONE)
                || (state_reg == PMBRT_IDLE && want_local && !gnt_n_i);
            first_reg <= 1'b1;
        end
    end

    // copy of the newest captured word, the next head when two words wait
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tail_reg <= PMBRT_DATA_RESET;
        end else if (phase_ok) begin
            tail_reg <= ad_i;
        end
    end

    // acknowledge and strobe toward the local master
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
            dxfr_reg <= 1'b0;
            dout_reg <= PMBRT_DATA_RESET;
        end else begin
            // ack needs a word captured; a target wait leaves none new
            ack_reg <= phase_ok || (hold_avail && !pop) || (hold_count > CW'(1));
            // strobe needs ack now and ready in the cycle before; mode end kills both
            dxfr_reg <= (phase_ok || (hold_avail && !pop) || (hold_count > CW'(1)))
                && !local_master_ready_n_i;
            if (phase_ok && !(hold_avail && !pop) && !(hold_count > CW'(1))) begin
                dout_reg <= ad_i;
            end else if (hold_avail && pop) begin
                // two words held: the newer one follows the head just sent
                dout_reg <= (hold_count > CW'(1)) ? tail_reg : hold_head;
            end else if (hold_avail) begin
                dout_reg <= hold_head;
            end
        end
    end

    // transfer status bits
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tsr_reg <= PMBRT_TSR_RESET;
        end else begin
            tsr_reg[PMBRT_TSR_ADDR_BIT] <= (state_reg == PMBRT_IDLE) && want_local && !gnt_n_i;
            // data mode holds from address phase until all words delivered
            tsr_reg[PMBRT_TSR_DATA_BIT] <= (state_reg == PMBRT_ADDR)
                || (state_reg == PMBRT_DATA)
                || ((state_reg == PMBRT_DONE) && (hold_count > CW'(1) || !pop)
                    && hold_avail);
            tsr_reg[PMBRT_TSR_XFER_BIT] <= phase_ok;
            tsr_reg[PMBRT_TSR_WIDE_BIT] <= (state_reg == PMBRT_DATA) && wide_reg
                && !ack64_n_i && !devsel_n_i;
        end
    end

    // outputs, all straight from flip-flops
    assign frame_n_o = !frame_reg;
    assign frame_oe_o = drv_reg;
    assign req64_n_o = !wide_reg;
    assign req64_oe_o = drv_reg;
    assign irdy_n_o = !irdy_reg;
    assign irdy_oe_o = drv_reg;
    assign req_n_o = !req_reg;
    assign master_data_acknowledge_n_o = !ack_reg;
    assign local_data_transfer_strobe_n_o = !dxfr_reg;
    assign low_dword_ack_n_o = !dxfr_reg;
    assign high_dword_ack_n_o = !dxfr_reg;
    assign local_data_o = dout_reg;
    assign master_transfer_status_o = tsr_reg;

    // checks
    AST_XFER_BIT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        phase_ok |=> master_transfer_status_o[PMBRT_TSR_XFER_BIT])
        else $error("status bit 8 missing after pci phase");
    AST_STROBE_ACK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !local_data_transfer_strobe_n_o |-> !master_data_acknowledge_n_o
        && !low_dword_ack_n_o && !high_dword_ack_n_o)
        else $error("strobe without acknowledges");
    AST_READY_STALL: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (local_master_ready_n_i && state_reg == PMBRT_DATA && frame_reg && !first_reg)
        |=> irdy_n_o && local_data_transfer_strobe_n_o)
        else $error("local stall not honoured");
    AST_FRAME_DROP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (frame_reg && last_req && phase_ok) |=> frame_n_o && req64_n_o && !irdy_n_o)
        else $error("final phase frame drop wrong");
    AST_END_IRDY: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_reg == PMBRT_DATA && !frame_reg && phase_ok) |=> irdy_n_o)
        else $error("irdy held after last phase");
    AST_NARROW: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_reg == PMBRT_IDLE && !gnt_n_i && local_wide_request_n_i
        && !local_narrow_request_n_i) |=> req64_n_o)
        else $error("req64 on narrow request");
    AST_FIRST_IRDY: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_reg == PMBRT_ADDR |=> !irdy_n_o)
        else $error("first phase irdy missing");
    AST_WAIT_ACK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!hold_avail && !phase_ok) |=> master_data_acknowledge_n_o
        && local_data_transfer_strobe_n_o)
        else $error("ack during target wait");
    AST_MODE_END: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(master_transfer_status_o[PMBRT_TSR_DATA_BIT]) |-> master_data_acknowledge_n_o
        && local_data_transfer_strobe_n_o)
        else $error("acknowledge or strobe left on at data mode end");
    AST_TWO_MORE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (last_req && phase_ok && frame_reg) |=> ##1 irdy_n_o)
        else $error("more than two phases after final");
    COV_BURST: cover property (@(posedge clk_i) disable iff (!resetn_i)
        state_reg == PMBRT_DATA ##1 state_reg == PMBRT_DONE);
    COV_LSTALL: cover property (@(posedge clk_i) disable iff (!resetn_i)
        (state_reg == PMBRT_DATA && local_master_ready_n_i && !first_reg));
    COV_TWAIT: cover property (@(posedge clk_i) disable iff (!resetn_i)
        (irdy_reg && trdy_n_i));
endmodule

// File: pmbrt_target.sv
`timescale 1ns/1ps
// pci target model: fast decode, one word per data phase, optional stall
module pmbrt_target (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic frame_n_i,
    input wire logic req64_n_i,
    input wire logic irdy_n_i,
    input wire logic wait_i,
    output logic trdy_n_o,
    output logic devsel_n_o,
    output logic ack64_n_o,
    output logic [pmbrt_pkg::PMBRT_DATA_W-1:0] ad_o
);
    import pmbrt_pkg::*;
    logic claim_reg; // transaction claimed
    logic [31:0] phase_reg; // data phases done so far
    logic [PMBRT_DATA_W-1:0] word; // word of the current phase
    assign word = {32'h1000_0000 + phase_reg, 32'h2000_0000 + phase_reg};
    // released bus shows the inverse, so stale data never looks right
    assign ad_o = claim_reg ? word : ~word;
    // claim after the address phase, count phases, release after the last
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            claim_reg <= 1'b0;
            phase_reg <= 32'h0;
            devsel_n_o <= 1'b1;
            ack64_n_o <= 1'b1;
            trdy_n_o <= 1'b1;
        end else if (!claim_reg) begin
            if (!frame_n_i) begin
                claim_reg <= 1'b1;
                phase_reg <= 32'h0;
                devsel_n_o <= 1'b0;
                ack64_n_o <= req64_n_i; // 64-bit only when asked
                trdy_n_o <= wait_i;
            end
        end else begin
            if (!irdy_n_i && !trdy_n_o) begin
                phase_reg <= phase_reg + 32'h1; // data phase done
            end
            if (!irdy_n_i && !trdy_n_o && frame_n_i) begin
                // last phase done: pulled-up lines float high
                claim_reg <= 1'b0;
                devsel_n_o <= 1'b1;
                ack64_n_o <= 1'b1;
                trdy_n_o <= 1'b1;
            end else begin
                trdy_n_o <= wait_i; // stall when told
            end
        end
    end
endmodule

// File: pci_master_burst_read_tail_test.sv
`timescale 1ns/1ps
// bench plays the local master; the target model answers on pci
module pci_master_burst_read_tail_test;
    import pmbrt_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic local_narrow_request_n_i = 1'b1;
    logic local_wide_request_n_i = 1'b1;
    logic local_final_transfer_request_n_i = 1'b1;
    logic local_master_ready_n_i = 1'b1;
    logic gnt_n_i = 1'b1;
    logic tgt_wait = 1'b0; // target stall request
    logic master_data_acknowledge_n_o, local_data_transfer_strobe_n_o;
    logic low_dword_ack_n_o, high_dword_ack_n_o, frame_n_o, frame_oe_o;
    logic req64_n_o, req64_oe_o, irdy_n_o, irdy_oe_o, req_n_o;
    logic trdy_n_i, devsel_n_i, ack64_n_i;
    logic [PMBRT_DATA_W-1:0] local_data_o, ad_i;
    logic [PMBRT_DATA_W-1:0] mask = '1; // narrow bursts score the low half only
    logic [PMBRT_TSR_W-1:0] master_transfer_status_o;
    logic prev_rdy_n = 1'b1, prev_done = 1'b0; // last cycle's ready and phase
    int fails = 0, tests_run = 0, cycles = 0;
    int words = 0, phases = 0; // words taken, pci phases done
    // released control lines are pulled up
    wire frame_w = frame_oe_o ? frame_n_o : 1'b1;
    wire irdy_w = irdy_oe_o ? irdy_n_o : 1'b1;
    wire req64_w = req64_oe_o ? req64_n_o : 1'b1;
    always #12.5 clk_i = ~clk_i;
    pmbrt_core uut (.clk_i, .resetn_i, .local_narrow_request_n_i, .local_wide_request_n_i,
        .local_final_transfer_request_n_i, .local_master_ready_n_i,
        .master_data_acknowledge_n_o, .local_data_transfer_strobe_n_o, .low_dword_ack_n_o,
        .high_dword_ack_n_o, .local_data_o, .master_transfer_status_o, .gnt_n_i, .ad_i,
        .trdy_n_i, .devsel_n_i, .ack64_n_i, .frame_n_o, .frame_oe_o, .req64_n_o,
        .req64_oe_o, .irdy_n_o, .irdy_oe_o, .req_n_o);
    pmbrt_target tgt (.clk_i, .resetn_i, .frame_n_i(frame_w), .req64_n_i(req64_w),
        .irdy_n_i(irdy_w), .wait_i(tgt_wait), .trdy_n_o(trdy_n_i), .devsel_n_o(devsel_n_i),
        .ack64_n_o(ack64_n_i), .ad_o(ad_i));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    // monitor: scores strobed words and the per-cycle handshake relations
    // sampled mid-cycle, where every registered output has settled
    always @(negedge clk_i) begin
        if (resetn_i) begin
            check(low_dword_ack_n_o, local_data_transfer_strobe_n_o);
            check(high_dword_ack_n_o, local_data_transfer_strobe_n_o);
            check(local_data_transfer_strobe_n_o, master_data_acknowledge_n_o | prev_rdy_n);
            check(master_transfer_status_o[PMBRT_TSR_XFER_BIT], prev_done);
            if (local_data_transfer_strobe_n_o === 1'b0) begin
                check(local_data_o & mask, {32'h1000_0000 + words, 32'h2000_0000 + words} & mask);
                words++;
            end
            prev_done = (irdy_w === 1'b0) && (trdy_n_i === 1'b0);
            if (prev_done) phases++;
            prev_rdy_n = local_master_ready_n_i;
        end else begin
            prev_rdy_n = 1'b1;
            prev_done = 1'b0;
        end
    end
    // hang guard: five short bursts need well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 3000) begin
            fails++;
            summarize();
        end
    end
    // request, grant at once, run up to the first data phase
    task automatic start(input bit w, input logic rdy_n);
        mask = w ? '1 : 64'h0000_0000_ffff_ffff;
        words = 0;
        phases = 0;
        @(posedge clk_i);
        local_narrow_request_n_i <= w;
        local_wide_request_n_i <= !w;
        local_master_ready_n_i <= rdy_n;
        gnt_n_i <= 1'b0;
        repeat (20) if (frame_w !== 1'b0) tick();
        check(req64_w, !w);
        check({req_n_o, master_transfer_status_o[PMBRT_TSR_ADDR_BIT]}, 2'b01);
        @(posedge clk_i);
        local_narrow_request_n_i <= 1'b1;
        local_wide_request_n_i <= 1'b1;
        gnt_n_i <= 1'b1;
        #1;
        check(irdy_n_o, 1'b0);
        check(master_transfer_status_o[PMBRT_TSR_DATA_BIT], 1'b1);
    endtask
    // final request with ready held until every word is handed over
    task automatic finish();
        int p0;
        @(posedge clk_i);
        local_final_transfer_request_n_i <= 1'b0;
        local_master_ready_n_i <= 1'b0;
        #1;
        p0 = phases;
        repeat (20) if (frame_w !== 1'b1) tick();
        check(irdy_n_o, 1'b0);
        check(req64_w, 1'b1);
        tick();
        check({irdy_w, devsel_n_i, ack64_n_i, trdy_n_i}, 4'hf);
        repeat (20) if (master_transfer_status_o[PMBRT_TSR_DATA_BIT] !== 1'b0) tick();
        check(master_data_acknowledge_n_o, 1'b1);
        check(local_data_transfer_strobe_n_o, 1'b1);
        check(words, phases);
        check(phases - p0 <= 2, 1'b1);
        @(posedge clk_i);
        local_final_transfer_request_n_i <= 1'b1;
        local_master_ready_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic test_wide_burst();
        start(1'b1, 1'b0);
        repeat (20) if (words < 3) tick();
        check(master_transfer_status_o[PMBRT_TSR_WIDE_BIT], 1'b1);
        finish();
        $display("test wide burst done");
    endtask
    task automatic test_narrow_burst();
        start(1'b0, 1'b0);
        repeat (4) begin
            tick();
            check(req64_w, 1'b1);
        end
        check(master_transfer_status_o[PMBRT_TSR_WIDE_BIT], 1'b0);
        finish();
        $display("test narrow burst done");
    endtask
    // master not ready at the start: first phase still runs, the next waits
    task automatic test_first_phase();
        start(1'b1, 1'b1);
        tick();
        check(irdy_n_o, 1'b1);
        check(master_data_acknowledge_n_o, 1'b0);
        finish();
        $display("test first phase done");
    endtask
    task automatic test_local_wait();
        start(1'b1, 1'b0);
        repeat (20) if (words < 2) tick();
        @(posedge clk_i);
        local_master_ready_n_i <= 1'b1;
        tick();
        check(local_data_transfer_strobe_n_o, 1'b1);
        check(irdy_n_o, 1'b1);
        @(posedge clk_i);
        local_master_ready_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        finish();
        $display("test local wait done");
    endtask
    task automatic test_target_wait();
        start(1'b1, 1'b0);
        repeat (20) if (words < 2) tick();
        @(posedge clk_i);
        tgt_wait <= 1'b1;
        tick();
        tick();
        check(master_data_acknowledge_n_o, 1'b1);
        check(local_data_transfer_strobe_n_o, 1'b1);
        @(posedge clk_i);
        tgt_wait <= 1'b0;
        repeat (3) @(posedge clk_i);
        finish();
        $display("test target wait done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        test_wide_burst();
        test_narrow_burst();
        test_first_phase();
        test_local_wait();
        test_target_wait();
        summarize();
    end
endmodule
